/* File: rtl/station_char_pkg.sv */
// Constants for the station character interface: address map, status and
// command bit positions, link widths and timing counts.
// Assumes a 24-bit byte-addressed host bus with big-endian byte lanes.
package station_char_pkg;

    // Character and address widths
    localparam int          CHAR_W              = 8;
    localparam int          ADDR_W              = 24;

    // Byte addresses
    localparam logic [23:0] STATION_COMMAND_ADDR        = 24'h07fffc;
    localparam logic [23:0] STATION_STATUS_ADDR         = 24'h07fffc;
    localparam logic [23:0] DATA_CHAR_PORT_ADDR         = 24'h07fffd;
    localparam logic [23:0] STATION_COMMAND_MIRROR_ADDR = 24'h07fffe;
    localparam logic [23:0] STATION_STATUS_MIRROR_ADDR  = 24'h07fffe;
    localparam logic [23:0] CONTROL_CHAR_PORT_ADDR      = 24'h07ffff;

    // Status bit positions
    localparam int          ST_INTERRUPTING     = 7;
    localparam int          ST_BEING_RESET      = 6;
    localparam int          ST_TX_EMPTY         = 3;
    localparam int          ST_RX_CTRL          = 2;
    localparam int          ST_RX_DATA          = 1;
    localparam int          ST_RX_ANY           = 0;

    // Command bit positions
    localparam int          CMD_RESET_STATION   = 6;
    localparam int          CMD_INT_TX_EMPTY    = 3;
    localparam int          CMD_INT_RX_CTRL     = 2;
    localparam int          CMD_INT_RX_DATA     = 1;

    // Reset values
    localparam logic [2:0]  INT_ENABLE_RESET    = 3'h0;
    localparam logic [7:0]  CHAR_RESET          = 8'h00;

    // Interrupt: autovector level and vector location
    localparam logic [2:0]  INT_LEVEL           = 3'h4;
    localparam logic [23:0] INT_VECTOR_ADDR     = 24'h000070;

    // Station reset pulse length
    localparam int          CLK_PERIOD_NS       = 8;
    localparam int          STATION_RESET_NS    = 1000;
    localparam int          STATION_RESET_CYC   =
        (STATION_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          RESET_CNT_W         = 8;

    // Synchroniser depth
    localparam int          SYNC_STAGES         = 2;

endpackage : station_char_pkg

/* File: rtl/level_sync.sv */
// Two flip-flop synchroniser for a single level arriving from the station.
// Assumes the input is a slow handshake level, stable for several cycles.
`timescale 1ns/10ps

module level_sync
(
    // Clock and reset
    input  wire logic mclk,
    input  wire logic resetn,
    // Level in and out
    input  wire logic asyncIn,
    output logic      syncOut
);
    import station_char_pkg::*;

    logic [SYNC_STAGES-1:0] stages;

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            stages <= '0;
        end
        else
        begin
            stages <= {stages[SYNC_STAGES-2:0], asyncIn};
        end
    end

    assign syncOut = stages[SYNC_STAGES-1];

endmodule : level_sync

/* File: rtl/station_char_interface.sv */
// Host register interface to a network station over a 9-bit character link.
// Assumes a big-endian host bus with byte strobes and a station that uses
// four-phase request/acknowledge handshakes in each direction.
//
// Functional notes
// - Characters flow both ways at once, each carrying 8 payload bits and a data/control marker.
// - Each direction has one 8-bit holding register with full/empty and data/control flags.
// - An interrupt is requested at autovector level four, vector longword at 000070.
// - Command writes and status reads share one byte address, mirrored at a second one.
// - Data characters share one byte address and control characters another, read rx, write tx.
// - A word read at either command/status address gives status high and the character low.
// - Status bit 7 is interrupting, bit 6 is station in reset, bits 5 and 4 read zero.
// - Status bits 3..0 are tx empty, control received, data received, and either received.
// - Writing one to command bit 6 resets the station; bits 7, 5, 4 and 0 do nothing.
// - Command bits 3, 2, 1 enable interrupts on tx empty, control received, data received.
// - Reading the data port clears the data received flag only.
// - Reading the control port clears the control received flag only.
// - The combined receive flag stays set while either receive flag is set.
`timescale 1ns/10ps

module station_char_interface
(
    // Clock and reset
    input  wire logic                              mclk,
    input  wire logic                              resetn,
    // Host bus
    input  wire logic                              busValid,
    input  wire logic                              busWrite,
    input  wire logic [station_char_pkg::ADDR_W-1:1] busAddr,
    input  wire logic                              busUpper,
    input  wire logic                              busLower,
    input  wire logic [15:0]                       busWdata,
    output logic      [15:0]                       busRdata,
    output logic                                   busAck,
    // Interrupt
    output logic                                   intReq,
    output logic      [2:0]                        intLevel,
    input  wire logic                              iackValid,
    input  wire logic [2:0]                        iackLevel,
    output logic                                   autoVector,
    // Station transmit link
    output logic      [station_char_pkg::CHAR_W-1:0] txChar,
    output logic                                   txIsCtrl,
    output logic                                   txReq,
    input  wire logic                              txAck,
    // Station receive link
    input  wire logic [station_char_pkg::CHAR_W-1:0] rxChar,
    input  wire logic                              rxIsCtrl,
    input  wire logic                              rxReq,
    output logic                                   rxAck,
    // Station reset
    output logic                                   stationReset
);
    import station_char_pkg::*;

    typedef enum logic [1:0] {TX_IDLE, TX_REQ, TX_DONE} tx_state_t;
    typedef enum logic       {RX_IDLE, RX_ACK}          rx_state_t;

    // Word address match against a byte address constant
    function automatic logic hitWord(input logic [ADDR_W-1:1] a, input logic [23:0] b);
        hitWord = (a == b[ADDR_W-1:1]);
    endfunction : hitWord

    tx_state_t              txState;
    rx_state_t              rxState;
    logic                   txAckSync;
    logic                   rxReqSync;
    logic [2:0]             intEnable;
    logic                   txEmpty;
    logic                   rxDataFlag;
    logic                   rxCtrlFlag;
    logic [CHAR_W-1:0]      rxHold;
    logic [RESET_CNT_W-1:0] resetCount;
    logic                   intActive;
    logic                   hitLow;
    logic                   hitHigh;
    logic                   busRead;
    logic                   busWr;
    logic                   readData;
    logic                   readCtrl;
    logic                   writeData;
    logic                   writeCtrl;
    logic                   writeCmd;
    logic                   rxCapture;
    logic [7:0]             statusByte;
    logic                   next_intActive;

    // Station handshake inputs come from another board and are resynchronised
    level_sync u_txAckSync
    (
        .mclk    (mclk),
        .resetn  (resetn),
        .asyncIn (txAck),
        .syncOut (txAckSync)
    );

    level_sync u_rxReqSync
    (
        .mclk    (mclk),
        .resetn  (resetn),
        .asyncIn (rxReq),
        .syncOut (rxReqSync)
    );

    // Address decode
    always_comb
    begin
        hitLow  = 1'b0;
        hitHigh = 1'b0;
        if (hitWord(busAddr, STATION_STATUS_ADDR))
        begin
            hitLow = 1'b1;
        end
        else if (hitWord(busAddr, STATION_STATUS_MIRROR_ADDR))
        begin
            hitHigh = 1'b1;
        end
    end

    assign busRead   = busValid && !busWrite && (hitLow || hitHigh);
    assign busWr     = busValid &&  busWrite && (hitLow || hitHigh);
    assign readData  = busRead && hitLow  && busLower;
    assign readCtrl  = busRead && hitHigh && busLower;
    assign writeData = busWr && hitLow  && busLower;
    assign writeCtrl = busWr && hitHigh && busLower;
    assign writeCmd  = busWr && busUpper;

    // Status byte; bits 5 and 4 are tied low
    always_comb
    begin
        statusByte                  = 8'h00;
        statusByte[ST_INTERRUPTING] = intActive;
        statusByte[ST_BEING_RESET]  = stationReset;
        statusByte[ST_TX_EMPTY]     = txEmpty;
        statusByte[ST_RX_CTRL]      = rxCtrlFlag;
        statusByte[ST_RX_DATA]      = rxDataFlag;
        statusByte[ST_RX_ANY]       = rxDataFlag || rxCtrlFlag;
    end

    // Bus answer one cycle after the strobe; unmapped addresses get no ack
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            busAck <= 1'b0;
        end
        else
        begin
            busAck <= busRead || busWr;
        end
    end

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            busRdata <= 16'h0000;
        end
        else if (busRead)
        begin
            busRdata[15:8] <= busUpper ? statusByte : 8'h00;
            busRdata[7:0]  <= busLower ? rxHold : 8'h00;
        end
    end

    // Interrupt enables; other command bits are not stored
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            intEnable <= INT_ENABLE_RESET;
        end
        else if (writeCmd)
        begin
            intEnable <= {busWdata[8+CMD_INT_TX_EMPTY],
                          busWdata[8+CMD_INT_RX_CTRL],
                          busWdata[8+CMD_INT_RX_DATA]};
        end
    end

    // Station reset pulse, restarted by each write of the reset bit
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            resetCount <= '0;
        end
        else if (writeCmd && busWdata[8+CMD_RESET_STATION])
        begin
            resetCount <= RESET_CNT_W'(STATION_RESET_CYC);
        end
        else if (resetCount != '0)
        begin
            resetCount <= resetCount - 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            stationReset <= 1'b0;
        end
        else
        begin
            stationReset <= (writeCmd && busWdata[8+CMD_RESET_STATION])
                            || (resetCount > RESET_CNT_W'(1));
        end
    end

    // Interrupt request, level four, autovectored
    assign next_intActive = |(intEnable & {txEmpty, rxCtrlFlag, rxDataFlag});

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            intActive <= 1'b0;
        end
        else
        begin
            intActive <= next_intActive;
        end
    end

    assign intReq   = intActive;
    assign intLevel = intActive ? INT_LEVEL : 3'h0;

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            autoVector <= 1'b0;
        end
        else
        begin
            autoVector <= iackValid && intActive && (iackLevel == INT_LEVEL);
        end
    end

    // Transmit holding register; writes while busy are dropped
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            txChar   <= CHAR_RESET;
            txIsCtrl <= 1'b0;
        end
        else if ((writeData || writeCtrl) && txEmpty)
        begin
            txChar   <= busWdata[7:0];
            txIsCtrl <= writeCtrl;
        end
    end

    // Transmit handshake: data held stable from request until ack falls
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            txState <= TX_IDLE;
            txReq   <= 1'b0;
            txEmpty <= 1'b1;
        end
        else
        begin
            case (txState)
                TX_IDLE:
                begin
                    if ((writeData || writeCtrl) && txEmpty)
                    begin
                        txEmpty <= 1'b0;
                        txReq   <= 1'b1;
                        txState <= TX_REQ;
                    end
                end
                TX_REQ:
                begin
                    if (txAckSync)
                    begin
                        txReq   <= 1'b0;
                        txState <= TX_DONE;
                    end
                end
                TX_DONE:
                begin
                    if (!txAckSync)
                    begin
                        txEmpty <= 1'b1;
                        txState <= TX_IDLE;
                    end
                end
                default:
                begin
                    txState <= TX_IDLE;
                end
            endcase
        end
    end

    // Receive side holds off the station until both flags are clear,
    // so one buffer never loses a character
    assign rxCapture = (rxState == RX_IDLE) && rxReqSync && !rxDataFlag && !rxCtrlFlag;

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            rxState <= RX_IDLE;
            rxAck   <= 1'b0;
        end
        else
        begin
            case (rxState)
                RX_IDLE:
                begin
                    if (rxCapture)
                    begin
                        rxAck   <= 1'b1;
                        rxState <= RX_ACK;
                    end
                end
                RX_ACK:
                begin
                    if (!rxReqSync)
                    begin
                        rxAck   <= 1'b0;
                        rxState <= RX_IDLE;
                    end
                end
                default:
                begin
                    rxState <= RX_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            rxHold <= CHAR_RESET;
        end
        else if (rxCapture)
        begin
            rxHold <= rxChar;
        end
    end

    // Set wins over a clear in the same cycle
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            rxDataFlag <= 1'b0;
        end
        else if (rxCapture && !rxIsCtrl)
        begin
            rxDataFlag <= 1'b1;
        end
        else if (readData)
        begin
            rxDataFlag <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            rxCtrlFlag <= 1'b0;
        end
        else if (rxCapture && rxIsCtrl)
        begin
            rxCtrlFlag <= 1'b1;
        end
        else if (readCtrl)
        begin
            rxCtrlFlag <= 1'b0;
        end
    end

endmodule : station_char_interface

/* File: dv/station_char_interface_sva.sv */
// Checker for the station character interface, bound to its top ports.
// Assumes the host keeps busValid to one-cycle pulses.
`timescale 1ns/10ps

module station_char_interface_sva
    import station_char_pkg::*;
(
    // Clock and reset
    input wire logic              mclk,
    input wire logic              resetn,
    // Host bus
    input wire logic              busValid,
    input wire logic              busWrite,
    input wire logic [ADDR_W-1:1] busAddr,
    input wire logic              busUpper,
    input wire logic              busLower,
    input wire logic [15:0]       busRdata,
    input wire logic              busAck,
    // Interrupt
    input wire logic              intReq,
    input wire logic [2:0]        intLevel,
    input wire logic              iackValid,
    input wire logic [2:0]        iackLevel,
    input wire logic              autoVector,
    // Links and station reset
    input wire logic              txReq,
    input wire logic              txAck,
    input wire logic              rxReq,
    input wire logic              rxAck,
    input wire logic              stationReset
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!resetn);

    wire logic hit = (busAddr == STATION_COMMAND_ADDR[23:1])
                     || (busAddr == STATION_COMMAND_MIRROR_ADDR[23:1]);

    a_ack_mapped: assert property (busValid && hit |=> busAck)
        else $error("mapped request not acknowledged next cycle");
    a_ack_unmapped: assert property (!(busValid && hit) |=> !busAck)
        else $error("acknowledge without a mapped request");
    a_int_level: assert property (intLevel == (intReq ? INT_LEVEL : 3'h0))
        else $error("interrupt level wrong");
    a_auto_vector: assert property (iackValid && iackLevel == INT_LEVEL && intReq
                                    |=> autoVector)
        else $error("autovector missing");
    a_tx_cause: assert property ($rose(txReq)
        |-> $past(busValid) && $past(busWrite) && $past(busLower))
        else $error("transmit request without a port write");
    a_tx_release: assert property ($rose(txAck) |-> ##[1:4] !txReq)
        else $error("transmit request not released");
    a_rx_cause: assert property ($rose(rxAck) |-> $past(rxReq, 1) && $past(rxReq, 2))
        else $error("receive acknowledge without request");
    a_status_zero: assert property (busAck && !$past(busWrite) && $past(busUpper)
                                    |-> busRdata[13:12] == 2'h0)
        else $error("unused status bits set");
    a_rx_any: assert property (busAck && !$past(busWrite) && $past(busUpper)
                               |-> busRdata[8] == (busRdata[9] | busRdata[10]))
        else $error("combined receive flag wrong");
    a_reset_len: assert property ($rose(stationReset) |-> stationReset[*8])
        else $error("station reset pulse too short");
    a_reset_cause: assert property ($rose(stationReset)
        |-> $past(busValid) && $past(busWrite) && $past(busUpper))
        else $error("station reset without command write");
endmodule : station_char_interface_sva

bind station_char_interface station_char_interface_sva chk (.mclk(mclk), .resetn(resetn),
    .busValid(busValid), .busWrite(busWrite), .busAddr(busAddr), .busUpper(busUpper),
    .busLower(busLower), .busRdata(busRdata), .busAck(busAck), .intReq(intReq),
    .intLevel(intLevel), .iackValid(iackValid), .iackLevel(iackLevel),
    .autoVector(autoVector), .txReq(txReq), .txAck(txAck), .rxReq(rxReq),
    .rxAck(rxAck), .stationReset(stationReset));

/* File: dv/station_model.sv */
// Behavioural network station on the far side of the character links.
// Assumes the interface clock; transmit acks alternate prompt and slow.
`timescale 1ns/10ps

module station_model
(
    // Clock
    input  wire logic       mclk,
    // Transmit link from the interface
    input  wire logic [7:0] txChar,
    input  wire logic       txIsCtrl,
    input  wire logic       txReq,
    output logic            txAck,
    // Receive link into the interface
    output logic [7:0]      rxChar,
    output logic            rxIsCtrl,
    output logic            rxReq,
    input  wire logic       rxAck
);
    logic [8:0] lastTx;
    int         txSeen;
    int         stalls;

    initial
    begin
        {txAck, rxReq, rxIsCtrl, rxChar, lastTx} = '0;
        txSeen = 0;
        stalls = 0;
        forever
        begin
            @(posedge mclk iff txReq);
            repeat (txSeen % 2 ? 5 : 1) @(posedge mclk);
            #1;
            lastTx = {txIsCtrl, txChar};
            txSeen++;
            txAck = 1'b1;
            for (int i = 0; i < 200 && txReq !== 1'b0; i++)
            begin
                @(posedge mclk);
            end
            stalls += int'(txReq !== 1'b0);
            #1;
            txAck = 1'b0;
        end
    end

    task automatic sendChar(input logic [8:0] c);
        @(posedge mclk);
        #1;
        {rxIsCtrl, rxChar} = c;
        rxReq = 1'b1;
        for (int i = 0; i < 200 && rxAck !== 1'b1; i++)
        begin
            @(posedge mclk);
            #1;
        end
        stalls += int'(rxAck !== 1'b1);
        rxReq = 1'b0;
        for (int i = 0; i < 200 && rxAck !== 1'b0; i++)
        begin
            @(posedge mclk);
            #1;
        end
        stalls += int'(rxAck !== 1'b0);
        // Released lines show the inverse, never a stale character
        {rxIsCtrl, rxChar} = ~c;
    endtask : sendChar
endmodule : station_model

/* File: dv/tb_station_char_interface.sv */
// Self-checking bench for the station character interface.
// Assumes the station model answers both links; the host bus is driven here.
`timescale 1ns/10ps

module tb_station_char_interface;
    import station_char_pkg::*;
    logic        mclk, resetn, busValid, busWrite, busUpper, busLower, busAck;
    logic        intReq, iackValid, autoVector, txIsCtrl, txReq, txAck;
    logic        rxIsCtrl, rxReq, rxAck, stationReset;
    logic [23:1] busAddr;
    logic [15:0] busWdata, busRdata;
    logic [2:0]  intLevel, iackLevel;
    logic [7:0]  txChar, rxChar;
    int          failures, check_count;

    station_char_interface DUT (.mclk(mclk), .resetn(resetn), .busValid(busValid),
        .busWrite(busWrite), .busAddr(busAddr), .busUpper(busUpper), .busLower(busLower),
        .busWdata(busWdata), .busRdata(busRdata), .busAck(busAck), .intReq(intReq),
        .intLevel(intLevel), .iackValid(iackValid), .iackLevel(iackLevel),
        .autoVector(autoVector), .txChar(txChar), .txIsCtrl(txIsCtrl), .txReq(txReq),
        .txAck(txAck), .rxChar(rxChar), .rxIsCtrl(rxIsCtrl), .rxReq(rxReq),
        .rxAck(rxAck), .stationReset(stationReset));

    station_model model (.mclk(mclk), .txChar(txChar), .txIsCtrl(txIsCtrl),
        .txReq(txReq), .txAck(txAck), .rxChar(rxChar), .rxIsCtrl(rxIsCtrl),
        .rxReq(rxReq), .rxAck(rxAck));

    initial
    begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    task automatic finish_test;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : finish_test

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp)
        begin
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
            failures++;
        end
    endtask : chk

    // One pulse request; acknowledge due exactly one cycle later
    task automatic bus(input logic wr, input logic [23:0] a, input logic [1:0] lanes,
                       input logic [15:0] wd, output logic [15:0] rd);
        // Idle edge first, so back-to-back calls never lower and raise busValid at once
        @(posedge mclk);
        #1;
        {busWrite, busAddr, busUpper, busLower, busWdata} = {wr, a[23:1], lanes, wd};
        busValid = 1'b1;
        @(posedge mclk);
        #1;
        busValid = 1'b0;
        chk("busAck", {15'h0, a[23:2] == 22'h01ffff}, {15'h0, busAck});
        rd = busRdata;
    endtask : bus

    task automatic stat(input logic [7:0] exp);
        logic [15:0] rd;
        bus(1'b0, STATION_STATUS_ADDR, 2'b10, 16'h0000, rd);
        chk("status", {8'h00, exp}, {8'h00, rd[15:8]});
    endtask : stat

    task automatic wait_stat(input logic [7:0] mask, input logic [7:0] val);
        logic [15:0] rd;
        for (int i = 0; i < 100; i++)
        begin
            bus(1'b0, STATION_STATUS_ADDR, 2'b10, 16'h0000, rd);
            if ((rd[15:8] & mask) === val)
                return;
        end
        chk("status wait", {8'h00, val}, {8'h00, rd[15:8] & mask});
        finish_test();
    endtask : wait_stat

    task automatic int_after(input logic exp);
        repeat (2) @(posedge mclk);
        #1;
        chk("intReq", {15'h0, exp}, {15'h0, intReq});
    endtask : int_after

    // A stalled receive or transmit handshake ends the run
    task automatic send_char(input logic [8:0] c);
        model.sendChar(c);
        chk("link stalls", 16'h0000, 16'(model.stalls));
        if (model.stalls != 0)
            finish_test();
    endtask : send_char

    task automatic t_map;
        logic [15:0] rd;
        bus(1'b0, STATION_STATUS_ADDR, 2'b11, 16'h0000, rd);
        chk("status word", 16'h0800, rd);
        bus(1'b0, STATION_STATUS_MIRROR_ADDR, 2'b11, 16'h0000, rd);
        chk("mirror word", 16'h0800, rd);
        bus(1'b0, 24'h07fffa, 2'b11, 16'h0000, rd);
        bus(1'b1, 24'h07fffa, 2'b01, 16'h00ff, rd);
    endtask : t_map

    task automatic t_tx;
        logic [15:0] rd;
        bus(1'b1, DATA_CHAR_PORT_ADDR, 2'b01, 16'h00a5, rd);
        stat(8'h00);
        // A write while busy must be dropped
        bus(1'b1, CONTROL_CHAR_PORT_ADDR, 2'b01, 16'h00ff, rd);
        wait_stat(8'h08, 8'h08);
        chk("tx data", 16'h00a5, {7'h0, model.lastTx});
        bus(1'b1, CONTROL_CHAR_PORT_ADDR, 2'b01, 16'h003c, rd);
        wait_stat(8'h08, 8'h08);
        chk("tx ctrl", 16'h013c, {7'h0, model.lastTx});
        chk("tx count", 16'h0002, 16'(model.txSeen));
    endtask : t_tx

    task automatic t_rx;
        logic [15:0] rd;
        send_char(9'h05a);
        wait_stat(8'h07, 8'h03);
        bus(1'b0, CONTROL_CHAR_PORT_ADDR, 2'b01, 16'h0000, rd);
        stat(8'h0b);
        bus(1'b0, STATION_STATUS_ADDR, 2'b11, 16'h0000, rd);
        chk("data word", 16'h0b5a, rd);
        stat(8'h08);
        send_char(9'h1c3);
        wait_stat(8'h07, 8'h05);
        bus(1'b0, DATA_CHAR_PORT_ADDR, 2'b01, 16'h0000, rd);
        stat(8'h0d);
        bus(1'b0, STATION_STATUS_MIRROR_ADDR, 2'b11, 16'h0000, rd);
        chk("ctrl word", 16'h0dc3, rd);
        stat(8'h08);
    endtask : t_rx

    task automatic t_int;
        logic [15:0] rd;
        bus(1'b1, STATION_COMMAND_ADDR, 2'b10, 16'h0800, rd);
        int_after(1'b1);
        chk("intLevel", 16'h0004, {13'h0, intLevel});
        stat(8'h88);
        iackLevel = INT_LEVEL;
        iackValid = 1'b1;
        @(posedge mclk);
        #1;
        iackValid = 1'b0;
        chk("autoVector", 16'h0001, {15'h0, autoVector});
        bus(1'b1, STATION_COMMAND_MIRROR_ADDR, 2'b10, 16'h0200, rd);
        int_after(1'b0);
        send_char(9'h011);
        wait_stat(8'h02, 8'h02);
        int_after(1'b1);
        bus(1'b0, DATA_CHAR_PORT_ADDR, 2'b01, 16'h0000, rd);
        int_after(1'b0);
        bus(1'b1, STATION_COMMAND_ADDR, 2'b10, 16'h0400, rd);
        send_char(9'h122);
        wait_stat(8'h04, 8'h04);
        int_after(1'b1);
        bus(1'b0, CONTROL_CHAR_PORT_ADDR, 2'b01, 16'h0000, rd);
        int_after(1'b0);
    endtask : t_int

    task automatic t_reset;
        logic [15:0] rd;
        int          n;
        bus(1'b1, STATION_COMMAND_ADDR, 2'b10, 16'hb100, rd);
        int_after(1'b0);
        chk("no reset", 16'h0000, {15'h0, stationReset});
        bus(1'b1, STATION_COMMAND_MIRROR_ADDR, 2'b10, 16'h4000, rd);
        n = 0;
        // Sample first: the pulse is already up when the write returns
        for (int i = 0; i < 300; i++)
        begin
            n += int'(stationReset === 1'b1);
            @(posedge mclk);
            #1;
        end
        chk("reset cycles", 16'(STATION_RESET_CYC), 16'(n));
        bus(1'b1, STATION_COMMAND_ADDR, 2'b10, 16'h4000, rd);
        repeat (2) @(posedge mclk);
        #1;
        stat(8'h48);
    endtask : t_reset

    initial
    begin
        {resetn, busValid, busWrite, busUpper, busLower, iackValid} = '0;
        {busAddr, busWdata, iackLevel} = '0;
        failures = 0;
        check_count = 0;
        repeat (8) @(posedge mclk);
        #1;
        resetn = 1'b1;
        t_map();
        t_tx();
        t_rx();
        t_int();
        t_reset();
        finish_test();
    end
endmodule : tb_station_char_interface
